// File: asp_serial_port.sv
/*
 Converter serial host port with result-ready signalling.
 // Behaviour
 // R1: Power-down low halts all port and conversion logic.
 // R2: Power-down entry and exit leave every stored register unchanged.
 // R3: Serial activity counts only while device select is low.
 // R4: Select tied low still gives a working three-wire link.
 // R5: Host may use select for bus sharing or as frame marker.
 // R6: In conversion mode ready goes low when a fresh word lands.
 // R7: Ready returns high after a full data word has been read.
 // R8: Unread word: ready high before update, held, then low again.
 // R9: Host should not start a data read while ready is high.
 // R10: Calibration: ready high at start, low at completion.
 // R11: Reads load the output shifter from the selected register.
 // R12: Writes go to comm, mode, filter or calibration; not status/data.
 // R13: Bits sampled and shifted once per serial clock period.
 Assumes the serial clock is far slower than clk_i (800 ns vs 100 ns),
 mode 3 framing (idle high, sample on rising, shift on falling), and a
 converter core upstream that pushes results and warns of updates.
*/
`timescale 1ns/10ps
module asp_serial_port (
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   input  wire logic              pwr_dn_n_i,
   input  wire logic              sel_n_i,
   input  wire logic              sclk_i,
   input  wire logic              sdi_i,
   output logic                   sdo_o,
   output logic                   sdo_oe_n_o,
   output logic                   rdy_n_o,
   input  wire logic              res_valid_i,
   output logic                   res_ready_o,
   input  wire asp_pkg::asp_result_s res_i,
   input  wire logic              upd_soon_i,
   input  wire logic              cal_start_i,
   output logic [23:0]            mode_o,
   output logic [23:0]            filter_o
);
   import asp_pkg::*;

   // ==========================================
   // Input synchronisers
   logic [1:0] sclk_sy_ff;
   logic [1:0] sel_sy_ff;
   logic [1:0] sdi_sy_ff;
   logic [1:0] pd_sy_ff;
   logic       sclk_d_ff;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sclk_sy_ff <= 2'h3;
         sel_sy_ff  <= 2'h3;
         sdi_sy_ff  <= 2'h0;
         pd_sy_ff   <= 2'h3;
         sclk_d_ff  <= 1'b1;
      end else begin
         sclk_sy_ff <= {sclk_sy_ff[0], sclk_i};
         sel_sy_ff  <= {sel_sy_ff[0], sel_n_i};
         sdi_sy_ff  <= {sdi_sy_ff[0], sdi_i};
         pd_sy_ff   <= {pd_sy_ff[0], pwr_dn_n_i};
         sclk_d_ff  <= sclk_sy_ff[1];
      end
   end

   logic run;
   logic active;
   logic sclk_rise;
   logic sclk_fall;
   assign run       = pd_sy_ff[1];                      // see R1
   assign active    = run && !sel_sy_ff[1];             // see R3 see R4
   assign sclk_rise = active && sclk_sy_ff[1] && !sclk_d_ff;  // see R13
   assign sclk_fall = active && !sclk_sy_ff[1] && sclk_d_ff;  // see R13

   // ==========================================
   // Result buffer
   asp_result_s buf_data;
   logic        buf_valid;
   logic        buf_take;
   logic        fifo_in_ready;
   logic [3:0]  hold_ff;
   asp_fifo #(
      .WIDTH ($bits(asp_result_s)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .in_valid_i  (res_valid_i && run),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (res_i),
      .out_valid_o (buf_valid),
      .out_ready_i (buf_take),
      .out_data_o  (buf_data)
   );
   // Halted core must not see its word accepted and then dropped
   assign res_ready_o = fifo_in_ready && run;                  // see R1

   // ==========================================
   // Registers; power-down only freezes them
   typedef enum logic [1:0] {PH_CMD, PH_WR, PH_RD} asp_phase_e;
   asp_phase_e  phase_ff;
   logic [7:0]  comm_ff;
   logic [23:0] mode_ff;
   logic [23:0] filter_ff;
   logic [23:0] offset_ff;
   logic [23:0] gain_ff;
   logic [23:0] data_ff;
   logic [23:0] status_ff;
   logic [23:0] sh_in_ff;
   logic [23:0] sh_out_ff;
   logic [4:0]  bitcnt_ff;
   logic        rdy_n_ff;
   logic        cal_busy_ff;
   logic        word_done;
   logic        cmd_done;
   asp_cmd_s    cmd;
   logic [23:0] rd_word;

   assign cmd       = '{rd: sh_in_ff[6], sel: sh_in_ff[2:0]};
   assign cmd_done  = sclk_rise && (phase_ff == PH_CMD) && (bitcnt_ff == 5'(CMD_W-1));
   assign word_done = sclk_rise && (phase_ff != PH_CMD) && (bitcnt_ff == 5'(WORD_W-1));
   // Update only after the warning hold and not mid-read of the data word
   assign buf_take  = run && buf_valid && (hold_ff == 4'h0)     // see R8
                      && !(phase_ff == PH_RD && comm_ff[2:0] == SEL_DATA);

   always_comb begin
      unique case (cmd.sel)
         SEL_STATUS: rd_word = status_ff;                 // see R11
         SEL_DATA:   rd_word = data_ff;
         SEL_MODE:   rd_word = mode_ff;
         SEL_FILTER: rd_word = filter_ff;
         SEL_OFFSET: rd_word = offset_ff;
         SEL_GAIN:   rd_word = gain_ff;
         default:    rd_word = 24'h000000;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase_ff  <= PH_CMD;
         bitcnt_ff <= BITCNT_RST;
         sh_in_ff  <= 24'h000000;
      end else if (!active) begin
         phase_ff  <= (run && sel_sy_ff[1]) ? PH_CMD : phase_ff; // see R2 see R5
         bitcnt_ff <= (run && sel_sy_ff[1]) ? BITCNT_RST : bitcnt_ff; // see R5
      end else if (sclk_rise) begin
         sh_in_ff  <= {sh_in_ff[22:0], sdi_sy_ff[1]};
         if (cmd_done || word_done) begin
            bitcnt_ff <= BITCNT_RST;
         end else begin
            bitcnt_ff <= bitcnt_ff + 5'h01;
         end
         if (cmd_done) begin
            // Read flag is the second command bit, already one place in
            phase_ff <= sh_in_ff[5] ? PH_RD : PH_WR;
         end else if (word_done) begin
            phase_ff <= PH_CMD;
         end
      end
   end

   // Command arrives in sh_in_ff one edge after cmd_done
   logic load_cmd_ff;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         load_cmd_ff <= 1'b0;
      end else begin
         load_cmd_ff <= cmd_done;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         comm_ff   <= COMM_RST;
         mode_ff   <= MODE_RST;
         filter_ff <= FILTER_RST;
         offset_ff <= OFFSET_RST;
         gain_ff   <= GAIN_RST;
      end else if (load_cmd_ff) begin
         comm_ff <= sh_in_ff[7:0];
      end else if (word_done && phase_ff == PH_WR) begin
         unique case (comm_ff[2:0])                        // see R12
            SEL_MODE:   mode_ff   <= {sh_in_ff[22:0], sdi_sy_ff[1]};
            SEL_FILTER: filter_ff <= {sh_in_ff[22:0], sdi_sy_ff[1]};
            SEL_OFFSET: offset_ff <= {sh_in_ff[22:0], sdi_sy_ff[1]};
            SEL_GAIN:   gain_ff   <= {sh_in_ff[22:0], sdi_sy_ff[1]};
            default:    comm_ff   <= comm_ff;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sh_out_ff <= 24'h000000;
      end else if (load_cmd_ff && cmd.rd) begin
         sh_out_ff <= rd_word;                             // see R11
      end else if (sclk_fall && phase_ff == PH_RD && bitcnt_ff != BITCNT_RST) begin
         // First fall of a read keeps the loaded MSB on the pin
         sh_out_ff <= {sh_out_ff[22:0], 1'b0};             // see R13
      end
   end

   assign sdo_o      = sh_out_ff[23];
   assign sdo_oe_n_o = !(active && phase_ff == PH_RD);

   // ==========================================
   // Data, status and result-ready
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         data_ff     <= 24'h000000;
         status_ff   <= 24'h000000;
         cal_busy_ff <= 1'b0;
      end else if (run) begin
         if (buf_take && !buf_data.is_cal) begin
            data_ff <= buf_data.word;
         end
         if (buf_take && buf_data.is_cal) begin
            cal_busy_ff <= 1'b0;
         end else if (cal_start_i) begin
            cal_busy_ff <= 1'b1;
         end
         status_ff <= {22'h000000, cal_busy_ff, rdy_n_ff};
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdy_n_ff <= 1'b1;
         hold_ff  <= 4'h0;
      end else if (run) begin
         if (upd_soon_i) begin
            hold_ff <= UPD_HOLD;
         end else if (hold_ff != 4'h0) begin
            hold_ff <= hold_ff - 4'h1;
         end
         if (buf_take) begin
            rdy_n_ff <= 1'b0;                              // see R6 see R10
         end else if (cal_start_i || upd_soon_i) begin
            rdy_n_ff <= 1'b1;                              // see R8 see R10
         end else if (word_done && phase_ff == PH_RD && comm_ff[2:0] == SEL_DATA) begin
            rdy_n_ff <= 1'b1;                              // see R7 see R9
         end
      end
   end

   assign rdy_n_o  = rdy_n_ff;
   assign mode_o   = mode_ff;
   assign filter_o = filter_ff;

   // ==========================================
   // Checks
   a_pd_freeze_mode: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // see R2
      !run |=> $stable(mode_ff) && $stable(filter_ff)) else $error("register changed in power-down");
   a_pd_no_ready: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // see R1
      !run |=> $stable(rdy_n_ff)) else $error("ready moved in power-down");
   a_desel_no_shift: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // see R3
      sel_sy_ff[1] |=> $stable(sh_out_ff) || $past(load_cmd_ff)) else $error("shift while deselected");
   a_update_ready_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // see R6
      buf_take |=> !rdy_n_o) else $error("ready not low after update");
   a_read_ready_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // see R7
      run && word_done && phase_ff == PH_RD && comm_ff[2:0] == SEL_DATA && !buf_take
      |=> rdy_n_o) else $error("ready not high after data read");
   a_warn_ready_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // see R8
      run && upd_soon_i && !buf_take |=> rdy_n_o) else $error("ready not high before update");
   a_cal_ready_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // see R10
      run && cal_start_i && !buf_take |=> rdy_n_o ##0 cal_busy_ff) else $error("cal start left ready low");
   a_read_loads_sel: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // see R11
      load_cmd_ff && cmd.rd && cmd.sel == SEL_MODE |=> sh_out_ff == $past(mode_ff)) else $error("wrong read source");
   a_no_write_data: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // see R12
      word_done && phase_ff == PH_WR && !buf_take |=> $stable(data_ff)) else $error("data written by host");
   a_bit_count: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // see R13
      sclk_rise && !cmd_done && !word_done |=> bitcnt_ff == $past(bitcnt_ff) + 5'h01) else $error("bit count slip");
endmodule

// File: asp_pkg.sv
/*
 Package for the converter serial host port: register selection codes,
 widths, reset values and the shared packed structs.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package asp_pkg;

   // ==========================================
   // Register selection codes
   localparam logic [2:0] SEL_COMM   = 3'h0;
   localparam logic [2:0] SEL_STATUS = 3'h0;
   localparam logic [2:0] SEL_DATA   = 3'h1;
   localparam logic [2:0] SEL_MODE   = 3'h2;
   localparam logic [2:0] SEL_FILTER = 3'h3;
   localparam logic [2:0] SEL_OFFSET = 3'h4;
   localparam logic [2:0] SEL_GAIN   = 3'h5;

   // ==========================================
   // Widths and reset values
   localparam int unsigned WORD_W = 24;
   localparam int unsigned CMD_W  = 8;
   localparam int unsigned FIFO_DEPTH = 32;
   localparam logic [23:0] MODE_RST   = 24'h000000;
   localparam logic [23:0] FILTER_RST = 24'h000000;
   localparam logic [23:0] OFFSET_RST = 24'h800000;
   localparam logic [23:0] GAIN_RST   = 24'h400000;
   localparam logic [7:0]  COMM_RST   = 8'h00;
   localparam logic [4:0]  BITCNT_RST = 5'h00;
   // Quiet time before an update during which ready is held high
   localparam logic [3:0]  UPD_HOLD   = 4'h4;

   // ==========================================
   // Carriers
   typedef struct packed {
      logic        rd;
      logic [2:0]  sel;
   } asp_cmd_s;

   typedef struct packed {
      logic        is_cal;
      logic [23:0] word;
   } asp_result_s;

endpackage

// File: asp_fifo.sv
/*
 Synchronous FIFO with valid/ready on both sides.
 Assumes one clock, asynchronous active-low reset.
*/
`timescale 1ns/10ps
module asp_fifo #(
   parameter int unsigned WIDTH = 25,
   parameter int unsigned DEPTH = 32
) (
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_ff;
   logic [AW-1:0]    rd_ptr_ff;
   logic [AW:0]      cnt_ff;
   logic             push;
   logic             pop;

   assign in_ready_o  = (cnt_ff != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_ff != '0);
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;
   assign out_data_o  = mem[rd_ptr_ff];

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr_ff] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         cnt_ff    <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
         end
         cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   a_fifo_no_overflow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      cnt_ff <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

// File: asp_host_model.sv
/*
 Host controller model driving the serial port: select, clock, data in.
 Assumes clk_i is the 100 ns system clock; serial clock is 800 ns.
*/
`timescale 1ns/10ps
module asp_host_model (
   input  wire logic clk_i,
   input  wire logic sdo_i,
   input  wire logic sdo_oe_n_i,
   output logic      sclk_o,
   output logic      sdi_o,
   output logic      sel_n_o
);
   // ==========================================
   // Idle: clock parked high, select released
   initial begin
      sclk_o  = 1'b1;
      sdi_o   = 1'b0;
      sel_n_o = 1'b1;
   end

   // ==========================================
   // One frame; sm 0 framed, 1 select tied low, 2 select left high
   task automatic xfer(input logic [7:0] cmd, input logic [23:0] wr, input int sm, output logic [23:0] rd);
      logic [31:0] sh;
      sh = {cmd, wr};
      rd = '0;
      @(negedge clk_i);
      sel_n_o = (sm == 2);
      repeat (4) @(negedge clk_i);
      for (int i = 0; i < 32; i++) begin
         sclk_o = 1'b0;
         sdi_o  = sh[31-i];
         repeat (4) @(negedge clk_i);
         // Undriven line reads inverted so it never passes by luck
         if (i >= 8) rd = {rd[22:0], sdo_oe_n_i ? ~sdo_i : sdo_i};
         sclk_o = 1'b1;
         repeat (4) @(negedge clk_i);
      end
      sdi_o   = ~sdi_o;
      sel_n_o = (sm != 1);
   endtask
endmodule

// File: asp_serial_port_bench.sv
/*
 Self-checking bench for the serial host port and ready signalling.
 Assumes asp_pkg, asp_fifo, asp_serial_port and asp_host_model.
*/
`timescale 1ns/10ps
module asp_serial_port_bench;
   import asp_pkg::*;
   logic        clk_i, rst_n_i, pwr_dn_n_i, sclk, sdi, sel_n, sdo, sdo_oe_n, rdy_n_o;
   logic        res_valid_i, res_ready_o, upd_soon_i, cal_start_i;
   asp_result_s res_i;
   logic [23:0] mode_o, filter_o, got;
   int          n_mismatch, checks_done;

   asp_serial_port i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .pwr_dn_n_i(pwr_dn_n_i), .sel_n_i(sel_n),
      .sclk_i(sclk), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n), .rdy_n_o(rdy_n_o),
      .res_valid_i(res_valid_i), .res_ready_o(res_ready_o), .res_i(res_i), .upd_soon_i(upd_soon_i),
      .cal_start_i(cal_start_i), .mode_o(mode_o), .filter_o(filter_o));
   asp_host_model i_host (.clk_i(clk_i), .sdo_i(sdo), .sdo_oe_n_i(sdo_oe_n), .sclk_o(sclk), .sdi_o(sdi),
      .sel_n_o(sel_n));

   // ==========================================
   // Clock, reset, watchdog
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   initial begin
      repeat (60000) @(posedge clk_i);
      n_mismatch++;
      end_sim();
   end

   // ==========================================
   // Shared tasks
   task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] seen);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [2:0] s, input logic [23:0] v, input int sm);
      i_host.xfer({5'h00, s}, v, sm, got);
   endtask
   task automatic rd(input logic [2:0] s, input int sm);
      i_host.xfer({5'h08, s}, 24'h000000, sm, got);
   endtask
   task automatic push(input logic c, input logic [23:0] w, output logic ok);
      @(negedge clk_i);
      res_valid_i = 1'b1;
      res_i = {c, w};
      ok = 1'b0;
      for (int k = 0; k < 3 && !ok; k++) begin
         ok = (res_ready_o === 1'b1);
         @(negedge clk_i);
      end
      res_valid_i = 1'b0;
   endtask
   task automatic pulse(input logic u);
      @(negedge clk_i);
      upd_soon_i  = u;
      cal_start_i = !u;
      @(negedge clk_i);
      upd_soon_i  = 1'b0;
      cal_start_i = 1'b0;
   endtask
   task automatic wait_rdy(input logic e, input int lim, input string nm);
      for (int k = 0; k < lim && rdy_n_o !== e; k++) @(negedge clk_i);
      chk(nm, {23'h0, e}, {23'h0, rdy_n_o});
   endtask

   // ==========================================
   // Scenarios
   task automatic t_regs();
      chk("reset mode", MODE_RST, mode_o);
      chk("reset ready", 24'h1, {23'h0, rdy_n_o});
      wr(SEL_MODE, 24'hA5C33C, 0);
      wr(SEL_FILTER, 24'h123456, 0);
      chk("mode written", 24'hA5C33C, mode_o);
      chk("filter written", 24'h123456, filter_o);
      rd(SEL_MODE, 0);
      chk("mode read", 24'hA5C33C, got);
      rd(SEL_OFFSET, 0);
      chk("offset reset", OFFSET_RST, got);
      rd(SEL_GAIN, 0);
      chk("gain reset", GAIN_RST, got);
      wr(SEL_OFFSET, 24'h00C0DE, 0);
      rd(SEL_OFFSET, 0);
      chk("offset read", 24'h00C0DE, got);
      wr(SEL_DATA, 24'hFFFFFF, 0);
      chk("mode after data write", 24'hA5C33C, mode_o);
      chk("filter after data write", 24'h123456, filter_o);
   endtask
   task automatic t_select();
      wr(SEL_MODE, 24'h000000, 2);
      chk("mode unselected", 24'hA5C33C, mode_o);
      wr(SEL_FILTER, 24'h0F0F0F, 1);
      rd(SEL_FILTER, 1);
      chk("three wire filter", 24'h0F0F0F, got);
      chk("three wire output", 24'h0F0F0F, filter_o);
   endtask
   task automatic t_fifo();
      logic ok;
      int   n;
      n = 0;
      ok = 1'b1;
      push(1'b0, 24'h0000FF, ok);
      wait_rdy(1'b0, 20, "ready on word");
      // Updates stall during a data read, so the buffer fills meanwhile
      fork
         rd(SEL_DATA, 0);
         begin
            wait (sdo_oe_n === 1'b0);
            while (ok && n < 40) begin
               push(1'b0, 24'h100 + n[23:0], ok);
               if (ok) n++;
            end
         end
      join
      chk("word read during fill", 24'h0000FF, got);
      chk("fifo depth", 24'(FIFO_DEPTH), 24'(n));
      wait_rdy(1'b0, 60, "ready after drain");
      rd(SEL_DATA, 0);
      chk("last drained word", 24'h100 + 24'(n - 1), got);
      wait_rdy(1'b1, 20, "ready after last read");
   endtask
   task automatic t_update();
      logic ok;
      push(1'b0, 24'hAAAAAA, ok);
      wait_rdy(1'b0, 20, "ready first word");
      pulse(1'b1);
      wait_rdy(1'b1, 10, "ready high before update");
      push(1'b0, 24'h555555, ok);
      wait_rdy(1'b0, 20, "ready low after update");
      rd(SEL_DATA, 0);
      chk("updated word", 24'h555555, got);
      wait_rdy(1'b1, 20, "ready after read");
      pulse(1'b0);
      wait_rdy(1'b1, 10, "ready at cal start");
      rd(SEL_STATUS, 0);
      chk("status cal busy", 24'h000003, got);
      push(1'b1, 24'h00BEEF, ok);
      wait_rdy(1'b0, 20, "ready at cal end");
      rd(SEL_STATUS, 0);
      chk("status cal done", 24'h000000, got);
   endtask
   task automatic t_power();
      @(negedge clk_i);
      pwr_dn_n_i = 1'b0;
      wr(SEL_MODE, 24'h777777, 0);
      chk("mode frozen", 24'hA5C33C, mode_o);
      @(negedge clk_i);
      pwr_dn_n_i = 1'b1;
      repeat (6) @(negedge clk_i);
      chk("mode kept", 24'hA5C33C, mode_o);
      chk("filter kept", 24'h0F0F0F, filter_o);
   endtask

   task automatic end_sim();
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      n_mismatch = 0;
      checks_done = 0;
      rst_n_i = 1'b0;
      pwr_dn_n_i = 1'b1;
      res_valid_i = 1'b0;
      res_i = '0;
      upd_soon_i = 1'b0;
      cal_start_i = 1'b0;
      repeat (16) @(negedge clk_i);
      rst_n_i = 1'b1;
      repeat (4) @(negedge clk_i);
      t_regs();
      t_select();
      t_fifo();
      t_update();
      t_power();
      end_sim();
   end
endmodule
